// File: sim/eep_host_tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// host controller bench
// ----------------------------------------------------------------
module eep_host_tb;
  import eep_pkg::*;
  logic      clk;
  logic      arst_n;
  logic      req_valid;
  logic      req_ready;
  logic      rsp_valid;
  logic      busy;
  logic      mdl_err;
  eep_req_t  req;
  eep_byte_t rsp_data;
  eep_byte_t dq_in;
  eep_byte_t dq_drv;
  eep_pins_t pins;
  eep_byte_t ref_mem [2048];
  int        miscompares = 0;
  int        total_checks = 0;
  int        cycles = 0;

  // host drive wins on the shared data lines
  assign dq_in = pins.dq_oe ? pins.dq_out : dq_drv;

  eep_host #(.PULSE_CYC(50), .VPP_FALL_CYC(20)) dut (
    .clk(clk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .busy(busy), .pins(pins), .dq_in(dq_in));

  eep_mem_model #(.ACC_CYC(100)) mdl (.clk(clk), .pins(pins), .dq_drv(dq_drv), .err(mdl_err));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      stop_test();
    end
  end

  always @(negedge clk) begin
    if (arst_n && pins.vpp_prog === 1'b1) check("rsp_in_prog", {7'h0, rsp_valid}, 8'h00);
  end

  // entered only while idle, so the request is taken at the second edge
  task automatic run(eep_cmd_t c, logic b, eep_addr_t a, eep_byte_t d);
    int   n;
    logic got;
    n   = 0;
    got = 1'b0;
    @(posedge clk);
    req       <= '{cmd: c, by_ce: b, addr: a, data: d};
    req_valid <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    check("ready_busy", {7'h0, req_ready}, 8'h00);
    while (busy !== 1'b0 && n < 3000) begin
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        check("rd_data", rsp_data, ref_mem[a]);
      end
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      miscompares++;
      stop_test();
    end
    check("rd_seen", {7'h0, got}, {7'h0, c == EEP_CMD_READ});
    check("ce_idle", {7'h0, pins.ce_n}, 8'h01);
    check("vpp_idle", {7'h0, pins.vpp_prog}, 8'h00);
    check("ready_idle", {7'h0, req_ready}, 8'h01);
  endtask

  task automatic prog(eep_cmd_t c, logic b, eep_addr_t a, eep_byte_t d);
    run(c, b, a, d);
    if (c == EEP_CMD_CHIP_ERASE) foreach (ref_mem[i]) ref_mem[i] = 8'hFF;
    else ref_mem[a] = (c == EEP_CMD_BYTE_WRITE) ? d : 8'hFF;
    run(EEP_CMD_READ, 1'b0, a, 8'h00);
    run(EEP_CMD_READ, 1'b0, a + 11'h001, 8'h00);
    run(EEP_CMD_READ, 1'b0, a - 11'h001, 8'h00);
  endtask

  initial begin
    arst_n    = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    foreach (ref_mem[i]) ref_mem[i] = 8'(i) ^ 8'hA5;
    void'($urandom(32'h4DA04DDE));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    run(EEP_CMD_READ, 1'b0, 11'h000, 8'h00);
    run(EEP_CMD_READ, 1'b0, 11'h7FF, 8'h00);
    prog(EEP_CMD_BYTE_WRITE, 1'b1, 11'h7FF, 8'h00);
    prog(EEP_CMD_BYTE_WRITE, 1'b0, 11'h000, 8'h5A);
    prog(EEP_CMD_BYTE_ERASE, 1'b0, 11'h000, 8'hFF);
    prog(EEP_CMD_BYTE_ERASE, 1'b1, 11'h7FF, 8'hFF);
    repeat (16) prog(eep_cmd_t'($urandom_range(2, 1)), 1'($urandom), 11'($urandom), 8'($urandom));
    prog(EEP_CMD_CHIP_ERASE, 1'b0, 11'h123, 8'h00);
    repeat (4) run(EEP_CMD_READ, 1'b0, 11'($urandom), 8'h00);
    prog(EEP_CMD_CHIP_ERASE, 1'b1, 11'h456, 8'h00);
    prog(EEP_CMD_BYTE_WRITE, 1'b1, 11'h456, 8'h3C);
    check("model_err", {7'h0, mdl_err}, 8'h00);
    stop_test();
  end
endmodule

// File: sim/eep_mem_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// behavioural memory device on the far side of the pins
// ----------------------------------------------------------------
module eep_mem_model
  import eep_pkg::*;
#(
  parameter int ACC_CYC = 113,
  parameter int PW_MIN  = 45,
  parameter int PW_MAX  = 75,
  parameter int CH_MIN  = 250
) (
  input  wire logic      clk,
  input  wire eep_pins_t pins,
  output      eep_byte_t dq_drv,
  output      logic      err
);
  eep_byte_t mem [2048];
  eep_addr_t addr_q;
  int        acc;
  int        pw;
  int        hi;
  int        ch_hi;
  logic      prog;
  logic      prog_q;

  // byte and chip modes both need the gate off the logic-low level
  assign prog = !pins.ce_n && pins.vpp_prog && pins.oe_n;

  initial begin
    err    = 1'b0;
    dq_drv = 8'h00;
    prog_q = 1'b0;
    acc    = 0;
    pw     = 0;
    hi     = 0;
    ch_hi  = 0;
    for (int i = 0; i < 2048; i++) mem[i] = 8'(i) ^ 8'hA5;
  end

  always @(posedge clk) begin
    addr_q <= pins.addr;
    prog_q <= prog;
    hi     <= pins.ce_n ? hi + 1 : 0;
    pw     <= prog ? pw + 1 : 0;
    if (!pins.ce_n && hi != 0) ch_hi <= hi;
    // lines wander until select, gate and address have been steady long enough
    if (pins.ce_n || pins.oe_n || pins.vpp_prog || pins.addr != addr_q) acc <= 0;
    else acc <= acc + 1;
    dq_drv <= (acc >= ACC_CYC) ? mem[pins.addr] : ~dq_drv;
    if (!pins.ce_n && pins.vpp_prog && !pins.oe_n) err <= 1'b1;
    if (prog && !prog_q && !pins.oe_hv && ((hi != 0) ? hi : ch_hi) < CH_MIN) err <= 1'b1;
    if (!prog && prog_q) begin
      if (pw < PW_MIN || pw > PW_MAX) err <= 1'b1;
      if (pins.oe_hv) begin
        for (int i = 0; i < 2048; i++) mem[i] <= 8'hFF;
      end else if (pins.dq_out == 8'hFF) begin
        mem[pins.addr] <= 8'hFF;
      end else begin
        // a write only clears bits, so a skipped erase shows on read
        mem[pins.addr] <= mem[pins.addr] & pins.dq_out;
      end
    end
  end
endmodule

// File: verilog/eep_host.sv
`timescale 1ns/10ps
`include "eep_timing_cfg.svh"

module eep_host #(
  parameter int unsigned PULSE_CYC    = `EEP_WP_CYC,
  parameter int unsigned VPP_FALL_CYC = `EEP_PFT_CYC
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire eep_pkg::eep_req_t  req,
  input  wire logic               req_valid,
  output      logic               req_ready,
  output      logic               rsp_valid,
  output      eep_pkg::eep_byte_t rsp_data,
  output      logic               busy,
  output      eep_pkg::eep_pins_t pins,
  input  wire eep_pkg::eep_byte_t dq_in
);
  import eep_pkg::*;

  eep_state_t  state;
  eep_state_t  next_state;
  eep_req_t    rq;
  eep_req_t    next_rq;
  logic        phase_wr;
  logic        next_phase;
  logic [31:0] timer;
  logic        tdone;
  eep_byte_t   dq_sync;

  eep_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      (dq_in),
    .q      (dq_sync)
  );

  // ----------------------------------------------------------------
  // state-to-pin decode
  // ----------------------------------------------------------------
  function automatic eep_pins_t pin_drive(eep_state_t st, eep_req_t r, logic wr);
    eep_pins_t p;
    p          = '0;
    p.addr     = r.addr;
    p.ce_n     = `EEP_PINS_IDLE_CE;
    p.oe_n     = 1'b1;
    p.dq_out   = (r.cmd == EEP_CMD_BYTE_WRITE && wr) ? r.data : `EEP_ERASED_BYTE;
    unique case (st)
      ST_IDLE, ST_FLOAT, ST_DROP: begin
        p.dq_out = '0;
      end
      ST_READ: begin
        p.ce_n   = 1'b0;
        p.oe_n   = 1'b0;
        p.dq_out = '0;
      end
      ST_DESEL: begin
        // select stays high: supply may already sit at program level
        p.vpp_prog = r.by_ce;
        p.oe_hv    = (r.cmd == EEP_CMD_CHIP_ERASE);
        p.dq_oe    = 1'b1;
      end
      ST_SETUP, ST_HOLD: begin
        p.ce_n     = r.by_ce;
        p.vpp_prog = r.by_ce;
        p.oe_hv    = (r.cmd == EEP_CMD_CHIP_ERASE);
        p.dq_oe    = 1'b1;
      end
      ST_PULSE: begin
        p.ce_n     = 1'b0;
        p.vpp_prog = 1'b1;
        p.oe_hv    = (r.cmd == EEP_CMD_CHIP_ERASE);
        p.dq_oe    = 1'b1;
      end
    endcase
    return p;
  endfunction

  function automatic logic [31:0] wait_for(eep_state_t st);
    logic [31:0] w;
    w = 32'h0000_0001;
    unique case (st)
      ST_IDLE:  w = 32'h0000_0001;
      ST_READ:  w = 32'(`EEP_ACC_CYC + `EEP_SYNC_CYC);
      ST_FLOAT: w = 32'(`EEP_DF_CYC);
      ST_DESEL: w = 32'(`EEP_CH_CYC);
      ST_SETUP: w = 32'(`EEP_CS_CYC);
      ST_PULSE: w = 32'(PULSE_CYC);
      ST_HOLD:  w = 32'(`EEP_AH_CYC);
      ST_DROP:  w = 32'(VPP_FALL_CYC);
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  assign tdone     = (timer == 32'h0000_0000);
  assign req_ready = (state == ST_IDLE);
  assign busy      = (state != ST_IDLE);

  always_comb begin
    next_state = state;
    next_rq    = rq;
    next_phase = phase_wr;
    unique case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_rq    = req;
          next_phase = 1'b0;
          next_state = (req.cmd == EEP_CMD_READ) ? ST_READ : ST_DESEL;
        end
      end
      ST_READ:  if (tdone) next_state = ST_FLOAT;
      ST_FLOAT: if (tdone) next_state = ST_IDLE;
      ST_DESEL: if (tdone) next_state = ST_SETUP;
      ST_SETUP: if (tdone) next_state = ST_PULSE;
      ST_PULSE: if (tdone) next_state = ST_HOLD;
      ST_HOLD: begin
        if (tdone) begin
          // erase phase done: write the same address next
          if (rq.cmd == EEP_CMD_BYTE_WRITE && !phase_wr) begin
            next_phase = 1'b1;
            next_state = ST_DESEL;
          end else begin
            next_state = ST_DROP;
          end
        end
      end
      ST_DROP:  if (tdone) next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= ST_IDLE;
      rq       <= '0;
      phase_wr <= 1'b0;
    end else begin
      state    <= next_state;
      rq       <= next_rq;
      phase_wr <= next_phase;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer <= 32'h0000_0000;
    end else if (next_state != state) begin
      timer <= wait_for(next_state) - 32'h0000_0001;
    end else if (!tdone) begin
      timer <= timer - 32'h0000_0001;
    end
  end

  // pins come straight from flops so no decode glitch reaches the memory
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pins      <= '0;
      pins.ce_n <= `EEP_PINS_IDLE_CE;
      pins.oe_n <= 1'b1;
    end else begin
      pins <= pin_drive(next_state, next_rq, next_phase);
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= (state == ST_READ) && tdone;
      if ((state == ST_READ) && tdone) begin
        rsp_data <= dq_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic        prog_active;
  logic        prog_q;
  logic [31:0] plen;
  logic [31:0] ce_hi_cnt;
  logic        erased_ok;
  eep_addr_t   erased_addr;

  assign prog_active = !pins.ce_n && pins.vpp_prog;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      plen      <= 32'h0000_0000;
      ce_hi_cnt <= 32'h0000_0000;
      prog_q    <= 1'b0;
    end else begin
      plen      <= prog_active ? plen + 32'h0000_0001 : 32'h0000_0000;
      ce_hi_cnt <= pins.ce_n ? ce_hi_cnt + 32'h0000_0001 : 32'h0000_0000;
      prog_q    <= prog_active;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      erased_ok   <= 1'b0;
      erased_addr <= '0;
    end else if (prog_q && !prog_active && !pins.oe_hv) begin
      erased_ok   <= (pins.dq_out == `EEP_ERASED_BYTE);
      erased_addr <= pins.addr;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence rd_taken;
    req_valid && req_ready && req.cmd == EEP_CMD_READ;
  endsequence

  sequence byte_pulse_start;
    $rose(prog_active) && !pins.oe_hv;
  endsequence

  rd_answer_a: assert property (rd_taken |-> ##[1:200] rsp_valid)
    else $error("read answer missing");
  rd_gate_a: assert property ($rose(rsp_valid) |-> !$past(pins.ce_n) && !$past(pins.oe_n))
    else $error("read sampled without select and gate low");
  no_contend_a: assert property (pins.dq_oe |-> pins.oe_n && !rsp_valid)
    else $error("host drives data while gate low");
  vpp_read_a: assert property (!pins.oe_n |-> !pins.vpp_prog)
    else $error("supply high during read");
  pulse_len_a: assert property ($fell(prog_active) |-> plen == PULSE_CYC)
    else $error("programming pulse length wrong");
  // at the falling edge the counter already holds the full high time
  desel_len_a: assert property ($fell(pins.ce_n) && pins.dq_oe |->
                                ce_hi_cnt >= `EEP_CH_CYC)
    else $error("select high time too short");
  erase_first_a: assert property (byte_pulse_start ##0 pins.dq_out != `EEP_ERASED_BYTE
                                  |-> erased_ok && erased_addr == pins.addr)
    else $error("write without prior erase");
  method_a: assert property ($rose(prog_active) |->
                             (rq.by_ce ? $past(pins.vpp_prog) : !$past(pins.ce_n)))
    else $error("pulse method mixed");
  oe_level_a: assert property (prog_active && rq.cmd != EEP_CMD_CHIP_ERASE |->
                               pins.oe_n && !pins.oe_hv)
    else $error("gate not at logic high in byte cycle");
  erase_ff_a: assert property (byte_pulse_start ##0 rq.cmd == EEP_CMD_BYTE_ERASE |->
                               pins.dq_out == `EEP_ERASED_BYTE [*3])
    else $error("byte erase data not all ones");

endmodule

// File: verilog/eep_pkg.sv
package eep_pkg;

  typedef logic [7:0]  eep_byte_t;
  typedef logic [10:0] eep_addr_t;

  typedef enum logic [1:0] {
    EEP_CMD_READ,
    EEP_CMD_BYTE_ERASE,
    EEP_CMD_BYTE_WRITE,
    EEP_CMD_CHIP_ERASE
  } eep_cmd_t;

  typedef struct packed {
    eep_cmd_t  cmd;
    logic      by_ce;
    eep_addr_t addr;
    eep_byte_t data;
  } eep_req_t;

  typedef struct packed {
    eep_addr_t addr;
    logic      ce_n;
    logic      oe_n;
    logic      oe_hv;
    logic      vpp_prog;
    eep_byte_t dq_out;
    logic      dq_oe;
  } eep_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_FLOAT,
    ST_DESEL,
    ST_SETUP,
    ST_PULSE,
    ST_HOLD,
    ST_DROP
  } eep_state_t;

endpackage

// File: verilog/eep_sync.sv
`timescale 1ns/10ps

module eep_sync (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire eep_pkg::eep_byte_t d,
  output      eep_pkg::eep_byte_t q
);
  import eep_pkg::*;

  eep_byte_t s1;
  eep_byte_t s2;
  eep_byte_t s3;

  // ----------------------------------------------------------------
  // three stages; a bit moves only once stages two and three agree
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_bit
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
        q[i]  <= 1'b0;
      end else begin
        s1[i] <= d[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end

endmodule

// File: verilog/eep_timing_cfg.svh
`ifndef EEP_TIMING_CFG_SVH
`define EEP_TIMING_CFG_SVH

// ----------------------------------------------------------------
// clock and pin timing, times in ns
// ----------------------------------------------------------------
`define EEP_CLK_NS        4
`define EEP_T_CH_NS       1000
`define EEP_T_CS_NS       150
`define EEP_T_AH_NS       50
`define EEP_T_ACC_NS      450
`define EEP_T_DF_NS       100
`define EEP_T_WP_NS       10000000
`define EEP_T_PFT_NS      100000

// least times round up to whole cycles
`define EEP_CYC_UP(ns)    (((ns) + `EEP_CLK_NS - 1) / `EEP_CLK_NS)
`define EEP_CH_CYC        `EEP_CYC_UP(`EEP_T_CH_NS)
`define EEP_CS_CYC        `EEP_CYC_UP(`EEP_T_CS_NS)
`define EEP_AH_CYC        `EEP_CYC_UP(`EEP_T_AH_NS)
`define EEP_ACC_CYC       `EEP_CYC_UP(`EEP_T_ACC_NS)
`define EEP_DF_CYC        `EEP_CYC_UP(`EEP_T_DF_NS)
`define EEP_WP_CYC        (`EEP_T_WP_NS / `EEP_CLK_NS)
`define EEP_PFT_CYC       `EEP_CYC_UP(`EEP_T_PFT_NS)
// input synchroniser latency margin
`define EEP_SYNC_CYC      4

// ----------------------------------------------------------------
// data values
// ----------------------------------------------------------------
`define EEP_ERASED_BYTE   8'hFF
`define EEP_PINS_IDLE_CE  1'b1

`endif
